// File: core/aoss_core.sv
// Analog output source select, percentage scaling and AXI4-Lite registers
// Summary of operation
// - Code 1 outputs the present output frequency.
// - Code 2 outputs setpoint synchronous speed without load slip.
// - Code 3 outputs the RMS output current.
// - Code 4 outputs load torque, 100 percent equal to torque reference.
// - Code 5 outputs the output voltage.
// - Code 6 outputs DC link voltage, 850 V equal to 100 percent.
// - Code 7 outputs the external analog value in any operating state.
// - Code 30 outputs set frequency before the ramp.
// - Code 31 outputs field bus process data directly.
// - Relay status functions are selectable as two-level outputs.
// - Digital condition true gives full scale, false gives zero.
// - An invert setting makes a true condition give zero.
// - Codes 15 to 25 pick status conditions, 44 to 51 bus bits.
// - Code 26 follows the external relay control value.
// - Scaling setting is signed, -500 to 500 percent, default 100.
// - Full scale equals scaling percent of the source normalisation.
// - Output is inversely proportional to the scaling setting.
// - Negative scaling: 0 percent gives full scale, -100 gives zero.
// - Scaling applies to analog codes only, not digital ones.
// - Code 0 produces no output.
// - A 0 percent analog source gives code zero with positive scaling.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module aoss_core #(
    parameter int DAC_W = 12
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_resetn,
    input  wire aoss_pkg::aoss_axi_req_s i_axi,
    output var  aoss_pkg::aoss_axi_rsp_s o_axi,
    input  wire aoss_pkg::aoss_drive_s  i_drive,
    output var  logic [DAC_W-1:0]       o_dac_code
);
    localparam logic [DAC_W-1:0] FULL = {DAC_W{1'b1}};
    localparam logic signed [47:0] FULL_W = 48'(FULL);

    typedef struct packed {
        logic [5:0]         output_source_select;
        logic signed [10:0] output_scale_percent;
        logic               invert_digital;
        logic [15:0]        external_analog_value;
        logic               external_relay_control;
        logic [15:0]        torque_reference_setting;
        logic               aw_ok;
        logic [7:0]         aw_addr;
        logic               w_ok;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        aoss_pkg::aoss_axi_rsp_s rsp;
        logic               dig_level;
        logic [DAC_W-1:0]   code;
    } aoss_state_s;

    aoss_state_s st;
    aoss_state_s next_st;

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic signed [10:0] clamp_scale(input logic signed [31:0] v);
        if (v > 32'(aoss_pkg::SCALE_MAX)) begin
            return aoss_pkg::SCALE_MAX;
        end else if (v < 32'(aoss_pkg::SCALE_MIN)) begin
            return aoss_pkg::SCALE_MIN;
        end
        return v[10:0];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a <= aoss_pkg::OFF_DIG && a[1:0] == 2'h0;
    endfunction

    // Selected analog source in Q14, ONE_Q14 is 100 percent
    logic signed [47:0] src_q;
    logic               src_analog;
    logic               dig_sel;
    logic               dig_raw;

    always_comb begin
        src_q = '0;
        src_analog = 1'b0;
        dig_sel = 1'b0;
        dig_raw = 1'b0;
        unique case (st.output_source_select)
            aoss_pkg::SRC_FREQ: begin
                src_q = 48'(i_drive.out_freq);
                src_analog = 1'b1;
            end
            aoss_pkg::SRC_SPEED: begin
                src_q = 48'(i_drive.sync_speed);
                src_analog = 1'b1;
            end
            aoss_pkg::SRC_CURR: begin
                src_q = 48'(i_drive.out_current);
                src_analog = 1'b1;
            end
            aoss_pkg::SRC_TORQUE: begin
                if (st.torque_reference_setting != 16'h0000) begin
                    src_q = (48'(i_drive.torque_current) * 48'(aoss_pkg::ONE_Q14))
                          / $signed({32'h0, st.torque_reference_setting});
                end
                src_analog = 1'b1;
            end
            aoss_pkg::SRC_VOLT: begin
                src_q = 48'(i_drive.out_voltage);
                src_analog = 1'b1;
            end
            aoss_pkg::SRC_DCLINK: begin
                src_q = $signed({32'h0, i_drive.dc_link_dv}) * 48'(aoss_pkg::ONE_Q14)
                      / 48'(aoss_pkg::DC_NORM_DV);
                src_analog = 1'b1;
            end
            aoss_pkg::SRC_EXTA: begin
                src_q = 48'($signed(st.external_analog_value));
                src_analog = 1'b1;
            end
            aoss_pkg::SRC_PRERMP: begin
                src_q = 48'(i_drive.pre_ramp_freq);
                src_analog = 1'b1;
            end
            aoss_pkg::SRC_BUSVAL: begin
                src_q = 48'(i_drive.bus_value);
                src_analog = 1'b1;
            end
            aoss_pkg::SRC_RELAY: begin
                dig_sel = 1'b1;
                dig_raw = st.external_relay_control;
            end
            default: begin
                if (st.output_source_select >= aoss_pkg::SRC_STAT0 &&
                    st.output_source_select <= aoss_pkg::SRC_STAT10) begin
                    dig_sel = 1'b1;
                    dig_raw = i_drive.status[4'(st.output_source_select
                                               - aoss_pkg::SRC_STAT0)];
                end else if (st.output_source_select >= aoss_pkg::SRC_BUSB0 &&
                             st.output_source_select <= aoss_pkg::SRC_BUSB7) begin
                    dig_sel = 1'b1;
                    dig_raw = i_drive.bus_bits[3'(st.output_source_select
                                                 - aoss_pkg::SRC_BUSB0)];
                end
            end
        endcase
    end

    // Scaling: full scale is scale percent of the normalisation value
    logic signed [47:0] num;
    logic signed [47:0] den;
    logic signed [47:0] quo;
    logic signed [47:0] lin;
    logic [DAC_W-1:0]   ana_code;

    always_comb begin
        num = src_q * 48'(aoss_pkg::PCT_FULL) * FULL_W;
        den = (st.output_scale_percent < 0)
            ? -48'(st.output_scale_percent) * 48'(aoss_pkg::ONE_Q14)
            : 48'(st.output_scale_percent) * 48'(aoss_pkg::ONE_Q14);
        quo = (den == 48'sd0) ? 48'sd0 : num / den;
        lin = (st.output_scale_percent < 0) ? FULL_W + quo : quo;
        if (lin <= 48'sd0) begin
            ana_code = '0;
        end else if (lin >= FULL_W) begin
            ana_code = FULL;
        end else begin
            ana_code = lin[DAC_W-1:0];
        end
    end

    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [31:0] wv;
    logic [31:0] rd;

    always_comb begin
        next_st = st;
        aw_take = i_axi.awvalid && st.rsp.awready;
        w_take = i_axi.wvalid && st.rsp.wready;
        ar_take = i_axi.arvalid && st.rsp.arready;
        if (aw_take) begin
            next_st.aw_ok = 1'b1;
            next_st.aw_addr = i_axi.awaddr;
        end
        if (w_take) begin
            next_st.w_ok = 1'b1;
            next_st.w_data = i_axi.wdata;
            next_st.w_strb = i_axi.wstrb;
        end
        if (st.rsp.bvalid && i_axi.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end
        wv = '0;
        if (st.aw_ok && st.w_ok) begin
            next_st.aw_ok = 1'b0;
            next_st.w_ok = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp = mapped(st.aw_addr) ? aoss_pkg::RESP_OKAY
                                                   : aoss_pkg::RESP_SLVERR;
            unique case (st.aw_addr)
                aoss_pkg::OFF_SRC: begin
                    wv = merge({26'h0, st.output_source_select}, st.w_data, st.w_strb);
                    next_st.output_source_select = wv[5:0];
                end
                aoss_pkg::OFF_SCALE: begin
                    wv = merge(32'(st.output_scale_percent), st.w_data, st.w_strb);
                    next_st.output_scale_percent = clamp_scale(wv);
                end
                aoss_pkg::OFF_INV: begin
                    wv = merge({31'h0, st.invert_digital}, st.w_data, st.w_strb);
                    next_st.invert_digital = wv[0];
                end
                aoss_pkg::OFF_EXTA: begin
                    wv = merge({16'h0, st.external_analog_value}, st.w_data, st.w_strb);
                    next_st.external_analog_value = wv[15:0];
                end
                aoss_pkg::OFF_EXTR: begin
                    wv = merge({31'h0, st.external_relay_control}, st.w_data, st.w_strb);
                    next_st.external_relay_control = wv[0];
                end
                aoss_pkg::OFF_TREF: begin
                    wv = merge({16'h0, st.torque_reference_setting}, st.w_data, st.w_strb);
                    next_st.torque_reference_setting = wv[15:0];
                end
                default: begin
                    wv = '0;
                end
            endcase
        end
        next_st.rsp.awready = !next_st.aw_ok && !next_st.rsp.bvalid;
        next_st.rsp.wready = !next_st.w_ok && !next_st.rsp.bvalid;

        unique case (i_axi.araddr)
            aoss_pkg::OFF_SRC:   rd = {26'h0, st.output_source_select};
            aoss_pkg::OFF_SCALE: rd = 32'(st.output_scale_percent);
            aoss_pkg::OFF_INV:   rd = {31'h0, st.invert_digital};
            aoss_pkg::OFF_EXTA:  rd = {16'h0, st.external_analog_value};
            aoss_pkg::OFF_EXTR:  rd = {31'h0, st.external_relay_control};
            aoss_pkg::OFF_TREF:  rd = {16'h0, st.torque_reference_setting};
            aoss_pkg::OFF_CODE:  rd = 32'(st.code);
            aoss_pkg::OFF_DIG:   rd = {31'h0, st.dig_level};
            default:             rd = '0;
        endcase
        if (st.output_source_select == aoss_pkg::SRC_OFF && i_axi.araddr == aoss_pkg::OFF_SRC) begin
            rd = '0;
        end
        if (st.rsp.rvalid && i_axi.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rdata = rd;
            next_st.rsp.rresp = mapped(i_axi.araddr) ? aoss_pkg::RESP_OKAY
                                                     : aoss_pkg::RESP_SLVERR;
        end
        next_st.rsp.arready = !next_st.rsp.rvalid;

        // Digital sources bypass scaling entirely
        next_st.dig_level = dig_raw ^ st.invert_digital;
        if (dig_sel) begin
            next_st.code = next_st.dig_level ? FULL : '0;
        end else if (src_analog) begin
            next_st.code = ana_code;
        end else begin
            next_st.code = '0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
            st.output_source_select <= aoss_pkg::SRC_RST;
            st.output_scale_percent <= aoss_pkg::SCALE_RST;
            st.torque_reference_setting <= aoss_pkg::TREF_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_axi = st.rsp;
    assign o_dac_code = st.code;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    off_zero_a: assert property (
        st.output_source_select == aoss_pkg::SRC_OFF |=> o_dac_code == '0)
        else $error("code not zero with source off");
    reserved_zero_a: assert property (
        (st.output_source_select inside {[6'h08:6'h0e], [6'h1b:6'h1d], [6'h20:6'h2b]})
        |=> o_dac_code == '0)
        else $error("reserved source gave nonzero code");
    status_high_a: assert property (
        st.output_source_select == 6'h10 && i_drive.status[1] && !st.invert_digital
        |=> o_dac_code == FULL)
        else $error("true condition not full scale");
    status_inv_a: assert property (
        st.output_source_select == 6'h10 && i_drive.status[1] && st.invert_digital
        |=> o_dac_code == '0)
        else $error("inverted true condition not zero");
    bus_bit_a: assert property (
        st.output_source_select == 6'h2e && !st.invert_digital
        |=> o_dac_code == ($past(i_drive.bus_bits[2]) ? FULL : '0))
        else $error("bus bit 2 not followed");
    relay_a: assert property (
        st.output_source_select == aoss_pkg::SRC_RELAY && !st.invert_digital
        |=> o_dac_code == ($past(st.external_relay_control) ? FULL : '0))
        else $error("relay control not followed");
    zero_src_a: assert property (
        st.output_source_select == aoss_pkg::SRC_FREQ && i_drive.out_freq == 16'sd0
        && st.output_scale_percent > 0 |=> o_dac_code == '0)
        else $error("zero source not zero code");
    neg_scale_a: assert property (
        st.output_source_select == aoss_pkg::SRC_FREQ && st.output_scale_percent == -11'sd100
        && i_drive.out_freq == -16'sd16384 |=> o_dac_code == '0)
        else $error("minus 100 percent not zero with negative scale");
    full_scale_a: assert property (
        st.output_source_select == aoss_pkg::SRC_FREQ && st.output_scale_percent == 11'sd200
        && i_drive.out_freq == 16'sd16384 |=> o_dac_code == FULL / 2)
        else $error("doubled scale did not halve output");
    scale_range_a: assert property (
        st.output_scale_percent <= aoss_pkg::SCALE_MAX
        && st.output_scale_percent >= aoss_pkg::SCALE_MIN)
        else $error("scale out of range");
    wr_resp_a: assert property (
        st.aw_ok && st.w_ok |=> o_axi.bvalid [*1] ##0 !o_axi.awready)
        else $error("write response missing");
    rd_resp_a: assert property (
        i_axi.arvalid && o_axi.arready |=> o_axi.rvalid && !o_axi.arready)
        else $error("read response missing");
    b_refuse_a: assert property (
        o_axi.bvalid |-> !o_axi.awready && !o_axi.wready)
        else $error("write accepted while response pending");
    rd_slverr_a: assert property (
        i_axi.arvalid && o_axi.arready && i_axi.araddr == 8'h20
        |=> o_axi.rresp == aoss_pkg::RESP_SLVERR && o_axi.rdata == '0)
        else $error("unmapped read not refused");
    sat_high_a: assert property (
        st.output_source_select == aoss_pkg::SRC_FREQ && st.output_scale_percent == 11'sd50
        && i_drive.out_freq == 16'sd16384 |=> o_dac_code == FULL)
        else $error("overrange not saturated");
    dc_half_a: assert property (
        st.output_source_select == aoss_pkg::SRC_DCLINK && st.output_scale_percent == 11'sd100
        && i_drive.dc_link_dv == 16'd4250 |=> o_dac_code == FULL / 2)
        else $error("half link voltage not half scale");
    torque_norm_a: assert property (
        st.output_source_select == aoss_pkg::SRC_TORQUE && st.output_scale_percent == 11'sd100
        && st.torque_reference_setting == 16'h2000 && i_drive.torque_current == 16'sd4096
        |=> o_dac_code == FULL / 2)
        else $error("torque not normalised to reference");
endmodule // aoss_core
`default_nettype wire

// File: pkg/aoss_pkg.sv
// Shared constants and carrier types for the analog output source scaler
package aoss_pkg;
    localparam int ADDR_W = 8;

    localparam logic [7:0] OFF_SRC   = 8'h00;
    localparam logic [7:0] OFF_SCALE = 8'h04;
    localparam logic [7:0] OFF_INV   = 8'h08;
    localparam logic [7:0] OFF_EXTA  = 8'h0c;
    localparam logic [7:0] OFF_EXTR  = 8'h10;
    localparam logic [7:0] OFF_TREF  = 8'h14;
    localparam logic [7:0] OFF_CODE  = 8'h18;
    localparam logic [7:0] OFF_DIG   = 8'h1c;

    localparam logic [5:0]         SRC_RST   = 6'h00;
    localparam logic signed [10:0] SCALE_RST = 11'sd100;
    localparam logic signed [10:0] SCALE_MAX = 11'sd500;
    localparam logic signed [10:0] SCALE_MIN = -11'sd500;
    localparam logic [15:0]        TREF_RST  = 16'h4000;

    // Normalised quantities: 100 percent equals ONE_Q14
    localparam int ONE_Q14   = 16384;
    localparam int DC_NORM_DV = 8500;
    localparam int PCT_FULL  = 100;

    localparam logic [5:0] SRC_OFF    = 6'h00;
    localparam logic [5:0] SRC_FREQ   = 6'h01;
    localparam logic [5:0] SRC_SPEED  = 6'h02;
    localparam logic [5:0] SRC_CURR   = 6'h03;
    localparam logic [5:0] SRC_TORQUE = 6'h04;
    localparam logic [5:0] SRC_VOLT   = 6'h05;
    localparam logic [5:0] SRC_DCLINK = 6'h06;
    localparam logic [5:0] SRC_EXTA   = 6'h07;
    localparam logic [5:0] SRC_STAT0  = 6'h0f;
    localparam logic [5:0] SRC_STAT10 = 6'h19;
    localparam logic [5:0] SRC_RELAY  = 6'h1a;
    localparam logic [5:0] SRC_PRERMP = 6'h1e;
    localparam logic [5:0] SRC_BUSVAL = 6'h1f;
    localparam logic [5:0] SRC_BUSB0  = 6'h2c;
    localparam logic [5:0] SRC_BUSB7  = 6'h33;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } aoss_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } aoss_axi_rsp_s;

    // Status bit k is the condition selected by source code 15 + k
    typedef struct packed {
        logic signed [15:0] out_freq;
        logic signed [15:0] sync_speed;
        logic signed [15:0] out_current;
        logic signed [15:0] torque_current;
        logic signed [15:0] out_voltage;
        logic [15:0]        dc_link_dv;
        logic signed [15:0] pre_ramp_freq;
        logic signed [15:0] bus_value;
        logic [10:0]        status;
        logic [7:0]         bus_bits;
    } aoss_drive_s;
endpackage

// File: dv/aoss_dac_model.sv
// Behavioural model of the 0 to 10 V output converter behind the block
`timescale 1ns/1ps
`default_nettype none
module aoss_dac_model #(
    parameter int FULL_MV = 10000
) (
    input  wire logic [11:0] i_code,
    output var  int          o_mv
);
    // Output voltage in millivolts, full code gives full scale
    always_comb begin
        o_mv = int'(i_code) * FULL_MV / 4095;
    end
endmodule // aoss_dac_model
`default_nettype wire

// File: dv/testbench.sv
// Self-checking testbench for the analog output source scaler
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {string nm; logic [31:0] d; logic [1:0] r; bit cd;} aoss_note_s;
    logic                    clk = 1'b0;
    logic                    rstn = 1'b0;
    aoss_pkg::aoss_axi_req_s ax;
    aoss_pkg::aoss_axi_rsp_s rs;
    aoss_pkg::aoss_drive_s   dr;
    aoss_pkg::aoss_drive_s   t;
    logic [11:0]             code;
    int                      mv;
    int                      error_cnt = 0;
    int                      checks = 0;
    aoss_note_s              rq[$];
    logic [1:0]              bq[$];
    logic [31:0]             seed = 32'hf8d5;
    logic signed [15:0]      s;
    logic [15:0]             x;
    int ac[8] = '{1, 2, 3, 4, 5, 7, 30, 31};
    int sc[4] = '{100, 200, 400, 50};
    int rc[7] = '{8, 14, 27, 29, 32, 43, 52};

    always #12.5 clk = ~clk;

    aoss_core #(.DAC_W(12)) i_dut (.i_core_clk(clk), .i_resetn(rstn), .i_axi(ax), .o_axi(rs),
                                   .i_drive(dr), .o_dac_code(code));
    aoss_dac_model i_dac (.i_code(code), .o_mv(mv));

    function automatic logic [15:0] nx();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h80200003 : 32'h0);
        return seed[15:0];
    endfunction

    function automatic logic [11:0] exp_code(input longint v, input longint k);
        longint q;
        if (k == 0) return 12'h000;
        q = (v * 100 * 4095) / ((k < 0 ? -k : k) * 16384);
        if (k < 0) q = 4095 + q;
        if (q < 0) q = 0;
        if (q > 4095) q = 4095;
        return q[11:0];
    endfunction

    // Scoreboard: oldest note against each response that appears
    always @(posedge clk) begin
        if (rstn && ax.bready && rs.bvalid) begin
            checks++;
            if (rs.bresp !== bq[0]) begin
                error_cnt++;
                $display("Error bresp expected %0h seen %0h", bq[0], rs.bresp);
            end
            void'(bq.pop_front());
        end
        if (rstn && ax.rready && rs.rvalid) begin
            checks++;
            if (rs.rdata !== rq[0].d || rs.rresp !== rq[0].r) begin
                error_cnt++;
                $display("Error %s expected %0h/%0h seen %0h/%0h", rq[0].nm, rq[0].d, rq[0].r,
                         rs.rdata, rs.rresp);
            end
            if (rq[0].cd) begin
                checks++;
                if (code !== rq[0].d[11:0] || mv !== int'(rq[0].d[11:0]) * 10000 / 4095) begin
                    error_cnt++;
                    $display("Error dac code expected %0h seen %0h", rq[0].d[11:0], code);
                end
            end
            void'(rq.pop_front());
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e = aoss_pkg::RESP_OKAY);
        bq.push_back(e);
        @(posedge clk);
        ax.awaddr <= a;
        ax.awvalid <= 1'b1;
        ax.wdata <= d;
        ax.wstrb <= 4'hf;
        ax.wvalid <= 1'b1;
        ax.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (ax.awvalid && rs.awready) ax.awvalid <= 1'b0;
            if (ax.wvalid && rs.wready) ax.wvalid <= 1'b0;
        end while (!(ax.bready && rs.bvalid));
        ax.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e = aoss_pkg::RESP_OKAY, input bit cd = 1'b0);
        rq.push_back('{$sformatf("reg %0h", a), d, e, cd});
        @(posedge clk);
        ax.araddr <= a;
        ax.arvalid <= 1'b1;
        ax.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (ax.arvalid && rs.arready) ax.arvalid <= 1'b0;
        end while (!(ax.rready && rs.rvalid));
        ax.rready <= 1'b0;
    endtask

    // Reads the live converter code after the inputs have settled
    task automatic chk(input logic [11:0] e);
        @(posedge clk);
        rd(aoss_pkg::OFF_CODE, {20'h0, e}, aoss_pkg::RESP_OKAY, 1'b1);
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        error_cnt++;
        $display("Error watchdog expected finish seen timeout");
        stop_test();
    end

    initial begin
        ax <= '0;
        dr <= '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(aoss_pkg::OFF_SRC, 32'h0);
        rd(aoss_pkg::OFF_SCALE, 32'h64);
        rd(aoss_pkg::OFF_TREF, 32'h4000);
        chk(12'h000);
        rd(8'h20, 32'h0, aoss_pkg::RESP_SLVERR);
        wr(8'h02, 32'h1, aoss_pkg::RESP_SLVERR);
        rd(aoss_pkg::OFF_SRC, 32'h0);
        wr(aoss_pkg::OFF_SCALE, 32'd600);
        rd(aoss_pkg::OFF_SCALE, 32'd500);
        wr(aoss_pkg::OFF_SCALE, -32'sd700);
        rd(aoss_pkg::OFF_SCALE, 32'hfffffe0c);
        wr(aoss_pkg::OFF_SCALE, 32'd100);
        foreach (ac[i]) begin
            t = dr;
            t.out_freq = nx() & 16'h3fff;
            t.sync_speed = nx() & 16'h3fff;
            t.out_current = nx() & 16'h3fff;
            t.torque_current = nx() & 16'h3fff;
            t.out_voltage = nx() & 16'h3fff;
            t.pre_ramp_freq = nx() & 16'h3fff;
            t.bus_value = nx() & 16'h3fff;
            x = nx() & 16'h3fff;
            dr <= t;
            wr(aoss_pkg::OFF_EXTA, {16'h0, x});
            wr(aoss_pkg::OFF_SRC, 32'(ac[i]));
            case (ac[i])
                1: s = t.out_freq;
                2: s = t.sync_speed;
                3: s = t.out_current;
                4: s = t.torque_current;
                5: s = t.out_voltage;
                7: s = x;
                30: s = t.pre_ramp_freq;
                default: s = t.bus_value;
            endcase
            chk(exp_code(s, 100));
        end
        t = dr;
        t.dc_link_dv = 16'd4250;
        dr <= t;
        wr(aoss_pkg::OFF_SRC, 32'd6);
        chk(12'd2047);
        t.torque_current = 16'sd4096;
        dr <= t;
        wr(aoss_pkg::OFF_TREF, 32'h2000);
        wr(aoss_pkg::OFF_SRC, 32'd4);
        chk(12'd2047);
        wr(aoss_pkg::OFF_TREF, 32'h4000);
        t.out_freq = 16'sd16384;
        dr <= t;
        wr(aoss_pkg::OFF_SRC, 32'd1);
        foreach (sc[i]) begin
            wr(aoss_pkg::OFF_SCALE, 32'(sc[i]));
            chk(exp_code(16384, sc[i]));
        end
        wr(aoss_pkg::OFF_SCALE, -32'sd100);
        foreach (sc[i]) begin
            t.out_freq = (i == 0) ? 16'sd0 : -16'sd16384 + 16'((i - 1) * 4096);
            dr <= t;
            chk(exp_code(t.out_freq, -100));
        end
        wr(aoss_pkg::OFF_SCALE, 32'd200);
        t.out_freq = 16'sd0;
        dr <= t;
        chk(12'h000);
        for (int k = 0; k < 19; k++) begin
            t.status = (k < 11) ? 11'h1 << k : 11'h0;
            t.bus_bits = (k < 11) ? 8'h0 : 8'h1 << (k - 11);
            dr <= t;
            wr(aoss_pkg::OFF_SRC, 32'((k < 11) ? 15 + k : 33 + k));
            chk(12'hfff);
            t.status = ~t.status;
            t.bus_bits = ~t.bus_bits;
            dr <= t;
            chk(12'h000);
        end
        wr(aoss_pkg::OFF_INV, 32'h1);
        chk(12'hfff);
        wr(aoss_pkg::OFF_SRC, 32'd16);
        chk(12'h000);
        wr(aoss_pkg::OFF_SRC, 32'd26);
        wr(aoss_pkg::OFF_EXTR, 32'h1);
        chk(12'h000);
        wr(aoss_pkg::OFF_INV, 32'h0);
        chk(12'hfff);
        wr(aoss_pkg::OFF_EXTR, 32'h0);
        chk(12'h000);
        t.status = '1;
        t.bus_bits = '1;
        t.bus_value = 16'sd8192;
        t.out_freq = 16'sd8192;
        dr <= t;
        wr(aoss_pkg::OFF_SCALE, 32'd100);
        foreach (rc[i]) begin
            wr(aoss_pkg::OFF_SRC, 32'(rc[i]));
            chk(12'h000);
        end
        wr(aoss_pkg::OFF_SRC, 32'd0);
        chk(12'h000);
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
